// ---- logic/flash_erase_suspend_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// erase / suspend / resume sequencer of the serial flash core
module flash_erase_suspend_seq #(
   parameter int unsigned WHOLE_ARRAY_ERASE_TIME_US = 1000,
   parameter int unsigned BLOCK_ERASE_TIME_US = 200,
   parameter int unsigned PROGRAM_TIME_US = 20
) (
   // core clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // serial link
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic MOSI,
   // array protection state
   input wire logic PROTECT_ANY,
   // program / block erase requests from sibling command logic
   input wire logic PROG_START,
   input wire logic BLKE_START,
   input wire logic [23:0] OP_ADDR,
   input wire logic [1:0] BLKE_SIZE,
   input wire logic OP_PROTECTED,
   // read address watch
   input wire logic [23:0] READ_ADDR,
   output logic READ_UNDEFINED,
   // status flags
   output logic READY_BUSY,
   output logic WRITE_LATCH_ARMED,
   output logic ERASE_HELD_FLAG,
   output logic PROGRAM_HELD_FLAG,
   output logic SUSPEND_LOCKOUT,
   // operation events
   output logic OP_ABORT,
   output logic OP_DONE
);
   import flash_seq_pkg::*;

   // =========================================================
   // cycle counts
   // core cycles per operation; 32 bits leave room for long erases
   // at the default times, so no count can wrap mid-operation
   localparam logic [31:0] ARRAY_ERASE_CYCLES =
      32'(WHOLE_ARRAY_ERASE_TIME_US * CLK_FREQ_MHZ);
   localparam logic [31:0] BLOCK_ERASE_CYCLES =
      32'(BLOCK_ERASE_TIME_US * CLK_FREQ_MHZ);
   localparam logic [31:0] PROGRAM_CYCLES =
      32'(PROGRAM_TIME_US * CLK_FREQ_MHZ);

   // =========================================================
   // helpers
   // addresses share a region when they agree above its size
   function automatic logic same_region(input logic [23:0] a,
                                        input logic [23:0] b,
                                        input logic [23:0] mask);
      same_region = ((a & mask) == (b & mask));
   endfunction

   // sizes two and three both select the largest block
   function automatic logic [23:0] block_mask(input logic [1:0] size);
      if (size == BLKE_SIZE_4K) begin
         block_mask = MASK_BLOCK_4K;
      end else if (size == BLKE_SIZE_32K) begin
         block_mask = MASK_BLOCK_32K;
      end else begin
         block_mask = MASK_BLOCK_64K;
      end
   endfunction

   // guard against a zero time collapsing the busy window
   function automatic logic [31:0] at_least_one(input logic [31:0] n);
      at_least_one = (n == CNT_RESET) ? 32'h1 : n;
   endfunction

   // =========================================================
   // state
   typedef struct packed {
      // select synchroniser and frame bookkeeping
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic cs_high;
      logic seen_parity;
      // operation in flight and its remaining cycles
      op_state_t state;
      logic [31:0] act_cnt;
      // write latch and suspended operations
      logic write_latch_armed;
      logic e_held;
      logic p_held;
      logic [31:0] erase_cnt;
      logic [31:0] prog_cnt;
      logic [23:0] erase_addr;
      logic [23:0] erase_mask;
      logic [23:0] prog_addr;
      // resume guard, one-cycle events and the read watch
      logic [2:0] settle_cnt;
      logic abort;
      logic done;
      logic read_undef;
   } core_t;

   core_t core_reg, core_next;

   // frame snapshot handed over from the link side
   logic [7:0] frame_opcode;
   logic frame_full;
   logic frame_aligned;
   logic frame_parity;
   // decoded per-cycle conditions
   logic release_evt;
   logic fresh_frame;
   logic clean_frame;
   logic busy_now;
   logic held_any;
   logic is_array_erase;

   // =========================================================
   // link domain capture
   // the capture runs on the serial clock and keeps its snapshot after
   // release; this side reads it only once the release has synced
   spi_frame_capture u_capture (
      .sck(SCK),
      .cs_n(CS_N),
      .mosi(MOSI),
      .link_rst_n(NRST),
      .frame_opcode(frame_opcode),
      .frame_full(frame_full),
      .frame_aligned(frame_aligned),
      .frame_parity(frame_parity)
   );

   // select release, seen once the second and third stages agree;
   // the snapshot is quiet by then because the serial clock stopped
   assign release_evt = core_reg.cs_s2 && core_reg.cs_s3 &&
                        !core_reg.cs_high;
   // a frame without clock edges leaves the parity unchanged
   assign fresh_frame = release_evt &&
                        (frame_parity != core_reg.seen_parity);
   assign clean_frame = fresh_frame && frame_full && frame_aligned;
   assign busy_now = (core_reg.state != ST_IDLE);
   assign held_any = core_reg.e_held || core_reg.p_held;
   assign is_array_erase = (frame_opcode == OPC_ARRAY_ERASE_A) ||
                           (frame_opcode == OPC_ARRAY_ERASE_B);

   // =========================================================
   // next state
   always_comb begin
      core_next = core_reg;
      core_next.abort = 1'b0;
      core_next.done = 1'b0;

      // select synchroniser, three stages
      core_next.cs_s1 = CS_N;
      core_next.cs_s2 = core_reg.cs_s1;
      core_next.cs_s3 = core_reg.cs_s2;
      if (core_reg.cs_s2 == core_reg.cs_s3) begin
         core_next.cs_high = core_reg.cs_s3;
      end
      if (fresh_frame) begin
         core_next.seen_parity = frame_parity;
      end

      // resume settle window counts down
      if (core_reg.settle_cnt != 3'h0) begin
         core_next.settle_cnt = core_reg.settle_cnt - 3'h1;
      end

      // self-timed operation progress
      // the count is one in the last busy cycle, so busy lasts
      // exactly as many edges as were loaded
      if (busy_now) begin
         core_next.act_cnt = core_reg.act_cnt - 32'h1;
         if (core_reg.act_cnt == 32'h1) begin
            core_next.state = ST_IDLE;
            core_next.done = 1'b1;
         end
      end

      // uneven release after a whole erase opcode disarms the latch
      // only outside a hold; a hold keeps the latch as it is
      if (fresh_frame && frame_full && !frame_aligned &&
          is_array_erase && !busy_now && !held_any) begin
         core_next.write_latch_armed = 1'b0;
      end

      // commands taken at a clean select release
      // every opcode here is judged on its first byte alone
      if (clean_frame) begin
         unique case (frame_opcode)
            OPC_WRITE_ENABLE: begin
               if (!busy_now) begin
                  core_next.write_latch_armed = 1'b1;
               end
            end

            OPC_WRITE_DISABLE: begin
               if (!busy_now) begin
                  core_next.write_latch_armed = 1'b0;
               end
            end

            OPC_ARRAY_ERASE_A, OPC_ARRAY_ERASE_B: begin
               // trailing bytes never matter, only the release does
               if (!busy_now && !held_any && core_reg.write_latch_armed) begin
                  if (PROTECT_ANY) begin
                     core_next.write_latch_armed = 1'b0;
                  end else begin
                     core_next.state = ST_ARRAY_ERASE;
                     core_next.act_cnt = at_least_one(ARRAY_ERASE_CYCLES);
                     core_next.write_latch_armed = 1'b0;
                  end
               end
            end

            OPC_SUSPEND: begin
               // latch state plays no part here; an operation in its
               // last cycle is left to finish rather than park a count
               // of one that a later resume would have to run off
               if (core_reg.settle_cnt == 3'h0 &&
                   core_reg.act_cnt != 32'h1) begin
                  if (core_reg.state == ST_BLOCK_ERASE) begin
                     core_next.state = ST_IDLE;
                     core_next.erase_cnt = core_reg.act_cnt;
                     core_next.e_held = 1'b1;
                  end else if (core_reg.state == ST_PROGRAM &&
                               !core_reg.e_held) begin
                     core_next.state = ST_IDLE;
                     core_next.prog_cnt = core_reg.act_cnt;
                     core_next.p_held = 1'b1;
                  end
                  // an array erase simply keeps running
               end
            end

            OPC_RESUME: begin
               if (!busy_now && held_any) begin
                  // the settle window keeps a quick suspend from
                  // catching the operation before it has restarted
                  core_next.settle_cnt = RESUME_SETTLE_CYCLES;
                  if (core_reg.p_held) begin
                     core_next.state = ST_PROGRAM;
                     core_next.act_cnt = at_least_one(core_reg.prog_cnt);
                     core_next.p_held = 1'b0;
                  end else begin
                     core_next.state = ST_BLOCK_ERASE;
                     core_next.act_cnt = at_least_one(core_reg.erase_cnt);
                     core_next.e_held = 1'b0;
                  end
               end
            end

            default: begin
               // other opcodes belong to sibling decoders
            end
         endcase
      end
      // short or uneven suspend / resume frames fall through untouched

      // program and block erase requests from sibling logic
      // a request meeting a clean frame in one cycle is dropped; both
      // come from the same link, so the siblings never overlap them
      if (!busy_now && !clean_frame && core_reg.write_latch_armed) begin
         // program wins when both requests come together and no program is held
         if (PROG_START && !core_reg.p_held) begin
            if (OP_PROTECTED) begin
               core_next.write_latch_armed = 1'b0;
               core_next.abort = 1'b1;
            end else if (core_reg.e_held &&
                         same_region(OP_ADDR, core_reg.erase_addr,
                                     core_reg.erase_mask)) begin
               core_next.write_latch_armed = 1'b0;
               core_next.abort = 1'b1;
            end else begin
               core_next.state = ST_PROGRAM;
               core_next.act_cnt = at_least_one(PROGRAM_CYCLES);
               core_next.prog_addr = OP_ADDR;
               core_next.write_latch_armed = 1'b0;
            end

         // an erase may not wipe the page of a held program
         end else if (BLKE_START && !core_reg.e_held) begin
            if (OP_PROTECTED) begin
               core_next.write_latch_armed = 1'b0;
               core_next.abort = 1'b1;
            end else if (core_reg.p_held &&
                         same_region(core_reg.prog_addr, OP_ADDR,
                                     block_mask(BLKE_SIZE))) begin
               core_next.write_latch_armed = 1'b0;
               core_next.abort = 1'b1;
            end else begin
               core_next.state = ST_BLOCK_ERASE;
               core_next.act_cnt = at_least_one(BLOCK_ERASE_CYCLES);
               core_next.erase_addr = OP_ADDR;
               core_next.erase_mask = block_mask(BLKE_SIZE);
               core_next.write_latch_armed = 1'b0;
            end
         end
      end

      // reads into a held page or block are flagged as garbage
      // registered, so the flag trails the address by one cycle
      core_next.read_undef =
         (core_reg.e_held &&
          same_region(READ_ADDR, core_reg.erase_addr,
                      core_reg.erase_mask)) ||
         (core_reg.p_held &&
          same_region(READ_ADDR, core_reg.prog_addr, MASK_PAGE));
   end

   // =========================================================
   // state register
   // select stages reset high, so no release is seen at start-up
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         core_reg <= '0;
         core_reg.cs_s1 <= 1'b1;
         core_reg.cs_s2 <= 1'b1;
         core_reg.cs_s3 <= 1'b1;
         core_reg.cs_high <= 1'b1;
         core_reg.state <= ST_IDLE;
      end else begin
         core_reg <= core_next;
      end
   end

   // =========================================================
   // outputs, all straight from the state register
   // nothing beyond a compare or an OR of the two held flags sits behind them, so they settle early
   assign READY_BUSY = (core_reg.state != ST_IDLE);
   assign WRITE_LATCH_ARMED = core_reg.write_latch_armed;
   assign ERASE_HELD_FLAG = core_reg.e_held;
   assign PROGRAM_HELD_FLAG = core_reg.p_held;
   // siblings must drop status writes and the like while held
   assign SUSPEND_LOCKOUT = held_any;
   assign READ_UNDEFINED = core_reg.read_undef;
   assign OP_ABORT = core_reg.abort;
   assign OP_DONE = core_reg.done;
endmodule
`default_nettype wire

// ---- logic/flash_seq_pkg.sv ----
// Functional notes
// - whole-array erase needs write latch armed first
// - two whole-array erase opcodes behave identically
// - no address; erase starts at select release
// - short or uneven frame: no erase, uneven clears latch
// - protected array: no erase, latch cleared
// - busy during erase; latch cleared before finishing
// - suspend: no address, latch ignored, acts at release
// - suspend sets held flag, device reports ready
// - short or uneven suspend frame does nothing
// - suspend ignored during whole-array erase
// - program allowed in erase hold, not suspendable
// - reads inside held region give undefined data
// - program into held erase block aborts, clears latch
// - erase over held program page aborts, clears latch
// - disallowed commands in hold ignored, latch kept
// - resume only when held and ready; latch ignored
// - resume continues operation, clears held, reports busy
// - short or uneven resume frame does nothing
// - double hold: resume program first, then erase
// - suspend ignored while resuming
// - write-enable opcode arms latch at clean release
`default_nettype none
package flash_seq_pkg;
   // =========================================================
   // opcodes
   localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OPC_ARRAY_ERASE_A = 8'h60;
   localparam logic [7:0] OPC_ARRAY_ERASE_B = 8'hC7;
   localparam logic [7:0] OPC_SUSPEND = 8'h75;
   localparam logic [7:0] OPC_RESUME = 8'h7A;
   // =========================================================
   // address region masks
   localparam logic [23:0] MASK_PAGE = 24'hFFFF00;
   localparam logic [23:0] MASK_BLOCK_4K = 24'hFFF000;
   localparam logic [23:0] MASK_BLOCK_32K = 24'hFF8000;
   localparam logic [23:0] MASK_BLOCK_64K = 24'hFF0000;
   localparam logic [1:0] BLKE_SIZE_4K = 2'h0;
   localparam logic [1:0] BLKE_SIZE_32K = 2'h1;
   // =========================================================
   // timing
   localparam int unsigned CLK_FREQ_MHZ = 25;
   localparam int unsigned RESUME_SETTLE_NS = 200;
   localparam logic [2:0] RESUME_SETTLE_CYCLES =
      3'((RESUME_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam logic [31:0] CNT_RESET = 32'h0;
   // =========================================================
   // operation states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARRAY_ERASE = 4'h2,
      ST_BLOCK_ERASE = 4'h4,
      ST_PROGRAM = 4'h8
   } op_state_t;
endpackage
`default_nettype wire

// ---- logic/spi_frame_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// link side: counts bits of one select frame on the serial clock
module spi_frame_capture (
   // link pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic link_rst_n,
   // frame snapshot, stable once select is released
   output logic [7:0] frame_opcode,
   output logic frame_full,
   output logic frame_aligned,
   output logic frame_parity
);
   import flash_seq_pkg::*;

   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] bits;
      logic started;
      logic full;
   } count_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic full;
      logic aligned;
      logic parity;
   } snap_t;

   count_t cnt_reg, cnt_next;
   snap_t snap_reg, snap_next;

   // next values for one serial clock edge inside the frame
   always_comb begin
      cnt_next = cnt_reg;
      snap_next = snap_reg;
      cnt_next.shift = {cnt_reg.shift[6:0], mosi};
      cnt_next.bits = cnt_reg.bits + 3'h1;
      cnt_next.started = 1'b1;
      if (cnt_reg.bits == 3'h7 && !cnt_reg.full) begin
         cnt_next.full = 1'b1;
         snap_next.opcode = cnt_next.shift;
      end
      snap_next.full = cnt_next.full;
      snap_next.aligned = (cnt_next.bits == 3'h0);
      // parity flips once per clocked frame so stale snapshots are seen
      if (!cnt_reg.started) begin
         snap_next.parity = ~snap_reg.parity;
      end
   end

   // counter dies with the frame: select release clears it at once
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // snapshot survives the release; the core reads it after sync
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         snap_reg <= '0;
      end else begin
         snap_reg <= snap_next;
      end
   end

   assign frame_opcode = snap_reg.opcode;
   assign frame_full = snap_reg.full;
   assign frame_aligned = snap_reg.aligned;
   assign frame_parity = snap_reg.parity;
endmodule
`default_nettype wire

// ---- verif/flash_seq_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// status port checker for the erase / suspend / resume sequencer
module flash_seq_assertions (
   // clock, reset and link
   input wire logic CLK, NRST, SCK, CS_N, MOSI,
   // sibling requests
   input wire logic PROTECT_ANY, PROG_START, BLKE_START, OP_PROTECTED,
   input wire logic [23:0] OP_ADDR, READ_ADDR,
   input wire logic [1:0] BLKE_SIZE,
   // status and events
   input wire logic READ_UNDEFINED, READY_BUSY, WRITE_LATCH_ARMED,
   input wire logic ERASE_HELD_FLAG, PROGRAM_HELD_FLAG, SUSPEND_LOCKOUT,
   input wire logic OP_ABORT, OP_DONE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // a resume also raises busy, so a start is a rise with no flag falling
   sequence s_start;
      $rose(READY_BUSY) && !$fell(ERASE_HELD_FLAG) && !$fell(PROGRAM_HELD_FLAG);
   endsequence
   sequence s_resume;
      $fell(ERASE_HELD_FLAG) || $fell(PROGRAM_HELD_FLAG);
   endsequence
   sequence s_hold;
      $rose(ERASE_HELD_FLAG) || $rose(PROGRAM_HELD_FLAG);
   endsequence
   AST_START_NEEDS_LATCH: assert property (s_start |-> $past(WRITE_LATCH_ARMED))
      else $error("operation started without armed latch");
   AST_START_CLEARS_LATCH: assert property (s_start |-> !WRITE_LATCH_ARMED)
      else $error("latch still armed after start");
   AST_ABORT_CLEARS_LATCH: assert property (OP_ABORT |-> !WRITE_LATCH_ARMED)
      else $error("abort left latch armed");
   AST_HOLD_READY: assert property (s_hold |-> !READY_BUSY)
      else $error("busy after suspend");
   AST_RESUME_BUSY: assert property (s_resume |-> READY_BUSY)
      else $error("not busy after resume");
   AST_RESUME_NEEDS_READY: assert property (s_resume |-> !$past(READY_BUSY))
      else $error("resume taken while busy");
   AST_PROGRAM_FIRST: assert property ($fell(ERASE_HELD_FLAG) |-> !PROGRAM_HELD_FLAG)
      else $error("erase resumed before held program");
   AST_NO_NESTED_HOLD: assert property ($rose(PROGRAM_HELD_FLAG) |-> !$past(ERASE_HELD_FLAG))
      else $error("program held during erase hold");
   AST_RESUME_SETTLE: assert property (s_resume |-> ##1 (!$rose(ERASE_HELD_FLAG) && !$rose(PROGRAM_HELD_FLAG)) [*5])
      else $error("suspend taken while resuming");
   AST_LOCKOUT: assert property (SUSPEND_LOCKOUT == (ERASE_HELD_FLAG || PROGRAM_HELD_FLAG))
      else $error("lockout differs from held flags");
   AST_READ_CLEAN: assert property (!SUSPEND_LOCKOUT && !$past(SUSPEND_LOCKOUT) |-> !READ_UNDEFINED)
      else $error("undefined read with nothing held");
   AST_DONE_PULSE: assert property (OP_DONE |-> !READY_BUSY ##1 !OP_DONE)
      else $error("done pulse malformed");
endmodule
bind flash_erase_suspend_seq flash_seq_assertions i_flash_seq_assertions (
   .CLK(CLK), .NRST(NRST), .SCK(SCK), .CS_N(CS_N), .MOSI(MOSI),
   .PROTECT_ANY(PROTECT_ANY), .PROG_START(PROG_START),
   .BLKE_START(BLKE_START), .OP_PROTECTED(OP_PROTECTED),
   .OP_ADDR(OP_ADDR), .READ_ADDR(READ_ADDR), .BLKE_SIZE(BLKE_SIZE),
   .READ_UNDEFINED(READ_UNDEFINED), .READY_BUSY(READY_BUSY),
   .WRITE_LATCH_ARMED(WRITE_LATCH_ARMED), .ERASE_HELD_FLAG(ERASE_HELD_FLAG),
   .PROGRAM_HELD_FLAG(PROGRAM_HELD_FLAG), .SUSPEND_LOCKOUT(SUSPEND_LOCKOUT),
   .OP_ABORT(OP_ABORT), .OP_DONE(OP_DONE));
`default_nettype wire

// ---- verif/spi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// host controller: mode 0 frames, 32 ns serial clock
module spi_host_model (
   // link pins toward the device
   output logic sck,
   output logic cs_n,
   output logic mosi
);
   // idle link: select high, clock parked low
   initial begin
      sck = 1'h0;
      cs_n = 1'h1;
      mosi = 1'h0;
   end
   // sends the first nbits of data, msb first; clock stands still between
   task automatic frame(input logic [15:0] data, input int nbits);
      #7;
      cs_n = 1'h0;
      for (int i = 0; i < nbits; i++) begin
         mosi = data[15 - i];
         #16 sck = 1'h1;
         #16 sck = 1'h0;
      end
      #16 cs_n = 1'h1;
      mosi = ~mosi; // released line must not show the last bit
   endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// self-checking bench for the erase / suspend / resume sequencer
module testbench;
   import flash_seq_pkg::*;
   localparam int ARRAY_CYC = 50; // 2 us at 25 cycles per us
   logic CLK, NRST, PROTECT_ANY, PROG_START, BLKE_START, OP_PROTECTED;
   logic SCK, CS_N, MOSI, READ_UNDEFINED, READY_BUSY, WRITE_LATCH_ARMED;
   logic ERASE_HELD_FLAG, PROGRAM_HELD_FLAG, SUSPEND_LOCKOUT, OP_ABORT, OP_DONE;
   logic [23:0] OP_ADDR, READ_ADDR;
   logic [1:0] BLKE_SIZE;
   int failures, n_tests, cycles, busy_cyc;
   spi_host_model i_spi_host_model (.sck(SCK), .cs_n(CS_N), .mosi(MOSI));
   flash_erase_suspend_seq #(.WHOLE_ARRAY_ERASE_TIME_US(2),
      .BLOCK_ERASE_TIME_US(4), .PROGRAM_TIME_US(4)) i_flash_erase_suspend_seq (
      .CLK(CLK), .NRST(NRST), .SCK(SCK), .CS_N(CS_N), .MOSI(MOSI),
      .PROTECT_ANY(PROTECT_ANY), .PROG_START(PROG_START),
      .BLKE_START(BLKE_START), .OP_ADDR(OP_ADDR), .BLKE_SIZE(BLKE_SIZE),
      .OP_PROTECTED(OP_PROTECTED), .READ_ADDR(READ_ADDR),
      .READ_UNDEFINED(READ_UNDEFINED), .READY_BUSY(READY_BUSY),
      .WRITE_LATCH_ARMED(WRITE_LATCH_ARMED), .ERASE_HELD_FLAG(ERASE_HELD_FLAG),
      .PROGRAM_HELD_FLAG(PROGRAM_HELD_FLAG), .SUSPEND_LOCKOUT(SUSPEND_LOCKOUT),
      .OP_ABORT(OP_ABORT), .OP_DONE(OP_DONE));
   // 25 MHz core clock
   initial begin
      CLK = 1'h0;
      forever #20 CLK = ~CLK;
   end
   // cycle ceiling cuts a hang short; busy cycles are counted alongside
   // sampled at the falling edge, where the outputs have settled
   always @(negedge CLK) begin
      cycles++;
      if (READY_BUSY === 1'h1) busy_cyc++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task check(input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge CLK);
   endtask
   // frame, then wait out the sync delay and the inter-frame gap
   task send(input logic [7:0] op, input int n);
      i_spi_host_model.frame({op, 8'hA5}, n);
      tick(8);
   endtask
   task we;
      send(OPC_WRITE_ENABLE, 8);
   endtask
   // one-cycle sibling request; its answer lands at the next edge
   task start(input logic prog, input logic [23:0] a);
      OP_ADDR = a;
      PROG_START = prog;
      BLKE_START = !prog;
      tick(1);
      PROG_START = 1'h0;
      BLKE_START = 1'h0;
   endtask
   // completion is found by polling busy, not by a fixed wait
   task wait_done;
      for (int n = 0; n < 400 && READY_BUSY === 1'h1; n++) tick(1);
      check(READY_BUSY, 1'h0);
      check(OP_DONE, 1'h1);
   endtask
   task t_latch;
      send(OPC_WRITE_ENABLE, 9);
      check(WRITE_LATCH_ARMED, 1'h0);
      send(OPC_WRITE_ENABLE, 16);
      check(WRITE_LATCH_ARMED, 1'h1);
      $display("t_latch done");
   endtask
   task t_array;
      logic [7:0] ops [2];
      ops = '{OPC_ARRAY_ERASE_A, OPC_ARRAY_ERASE_B};
      foreach (ops[i]) begin
         we();
         busy_cyc = 0;
         send(ops[i], 16);
         check(READY_BUSY, 1'h1);
         check(WRITE_LATCH_ARMED, 1'h0);
         send(OPC_SUSPEND, 8);
         check(ERASE_HELD_FLAG, 1'h0);
         check(READY_BUSY, 1'h1);
         wait_done();
         check(busy_cyc == ARRAY_CYC, 1'h1);
      end
      $display("t_array done");
   endtask
   task t_refuse;
      send(OPC_ARRAY_ERASE_A, 8);
      check(READY_BUSY, 1'h0);
      we();
      send(OPC_ARRAY_ERASE_B, 4);
      check(READY_BUSY, 1'h0);
      send(OPC_ARRAY_ERASE_A, 12);
      check(READY_BUSY, 1'h0);
      check(WRITE_LATCH_ARMED, 1'h0);
      we();
      PROTECT_ANY = 1'h1;
      send(OPC_ARRAY_ERASE_B, 8);
      check(READY_BUSY, 1'h0);
      check(WRITE_LATCH_ARMED, 1'h0);
      PROTECT_ANY = 1'h0;
      $display("t_refuse done");
   endtask
   task t_erase_hold;
      we();
      start(1'h0, 24'h010000);
      check(READY_BUSY, 1'h1);
      send(OPC_SUSPEND, 9);
      check(ERASE_HELD_FLAG, 1'h0);
      send(OPC_SUSPEND, 16);
      check(ERASE_HELD_FLAG, 1'h1);
      check(READY_BUSY, 1'h0);
      check(SUSPEND_LOCKOUT, 1'h1);
      READ_ADDR = 24'h010FFF;
      tick(2);
      check(READ_UNDEFINED, 1'h1);
      READ_ADDR = 24'h011000;
      tick(2);
      check(READ_UNDEFINED, 1'h0);
      we();
      start(1'h1, 24'h010100);
      check(OP_ABORT, 1'h1);
      check(WRITE_LATCH_ARMED, 1'h0);
      we();
      start(1'h1, 24'h020000);
      check(READY_BUSY, 1'h1);
      send(OPC_SUSPEND, 8);
      check(PROGRAM_HELD_FLAG, 1'h0);
      wait_done();
      send(OPC_RESUME, 12);
      check(ERASE_HELD_FLAG, 1'h1);
      send(OPC_RESUME, 8);
      check(ERASE_HELD_FLAG, 1'h0);
      check(READY_BUSY, 1'h1);
      send(OPC_SUSPEND, 8);
      check(ERASE_HELD_FLAG, 1'h1);
      send(OPC_RESUME, 8);
      check(ERASE_HELD_FLAG, 1'h0);
      wait_done();
      $display("t_erase_hold done");
   endtask
   task t_double;
      we();
      start(1'h1, 24'h030000);
      send(OPC_SUSPEND, 8);
      check(PROGRAM_HELD_FLAG, 1'h1);
      we();
      BLKE_SIZE = 2'h1;
      start(1'h0, 24'h037000);
      check(OP_ABORT, 1'h1);
      check(WRITE_LATCH_ARMED, 1'h0);
      we();
      BLKE_SIZE = 2'h2;
      start(1'h0, 24'h040000);
      send(OPC_SUSPEND, 8);
      check(ERASE_HELD_FLAG, 1'h1);
      READ_ADDR = 24'h04F000;
      tick(2);
      check(READ_UNDEFINED, 1'h1);
      send(OPC_RESUME, 8);
      check(PROGRAM_HELD_FLAG, 1'h0);
      send(OPC_RESUME, 8);
      check(ERASE_HELD_FLAG, 1'h1);
      wait_done();
      send(OPC_RESUME, 8);
      check(ERASE_HELD_FLAG, 1'h0);
      wait_done();
      $display("t_double done");
   endtask
   // reset for ten cycles, then the scenarios in turn
   initial begin
      NRST = 1'h0;
      {PROTECT_ANY, PROG_START, BLKE_START, OP_PROTECTED} = 4'h0;
      OP_ADDR = 24'h000000;
      READ_ADDR = 24'h000000;
      BLKE_SIZE = 2'h0;
      tick(10);
      NRST = 1'h1;
      tick(2);
      check(|{READY_BUSY, WRITE_LATCH_ARMED, SUSPEND_LOCKOUT, OP_DONE}, 1'h0);
      t_latch();
      t_array();
      t_refuse();
      t_erase_hold();
      t_double();
      stop_test();
   end
endmodule
`default_nettype wire
